// ### hw/io_port_pkg.sv
// Shared constants and types for the four-bit input and two-bit output port block.
package io_port_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;
  localparam int IN_W = 4;
  localparam int OUT_W = 2;
  localparam logic [ADDR_W-1:0] IO_LO_ADDR = 8'he0;
  localparam logic [ADDR_W-1:0] IO_HI_ADDR = 8'hfd;
  localparam logic [ADDR_W-1:0] INPUT_LEVEL_ADDR = 8'he0;
  localparam logic [ADDR_W-1:0] INPUT_IRQ_ENABLE_ADDR = 8'he8;
  localparam logic [ADDR_W-1:0] INPUT_IRQ_FLAG_ADDR = 8'hed;
  localparam logic [ADDR_W-1:0] OUTPUT_LATCH_ADDR = 8'hf3;
  localparam int FLAG_BIT = 0;
  localparam int OUT0_BIT = 0;
  localparam int OUT1_BIT = 1;
  localparam logic [IN_W-1:0] ENABLE_RESET = 4'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [OUT_W-1:0] LATCH_RESET = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 4'h0;
  localparam logic [IN_W-1:0] SYNC_RESET = 4'h0;
  typedef enum logic [1:0] {
    PIN0_PLAIN = 2'b00,
    PIN0_DIV_CLK = 2'b01,
    PIN0_TONE_N = 2'b10
  } pin0_mode_t;
  typedef enum logic [0:0] {
    PIN1_PLAIN = 1'b0,
    PIN1_TONE = 1'b1
  } pin1_mode_t;
  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10
  } irq_edge_t;
endpackage : io_port_pkg

// ### hw/pin_sync_if.sv
// Synchronised pin levels and their edges, passed from the synchroniser to the port logic.
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(parameter int W = 4);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : pin_sync_if
`default_nettype wire

// ### hw/pin_sync.sv
// Two-stage synchroniser for the input pins with edge detection on the settled level.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Raw pins and synchronised view
  input wire logic [W-1:0] pins,
  pin_sync_if.src sync
);
  logic [W-1:0] meta_q, meta_d;
  logic [W-1:0] level_q, level_d;
  logic [W-1:0] prev_q, prev_d;

  // The edge detector compares the second and third stages, never the first.
  always_comb begin
    meta_d = pins;
    level_d = meta_q;
    prev_d = level_q;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_q <= io_port_pkg::SYNC_RESET;
      level_q <= io_port_pkg::SYNC_RESET;
      prev_q <= io_port_pkg::SYNC_RESET;
    end else begin
      meta_q <= meta_d;
      level_q <= level_d;
      prev_q <= prev_d;
    end
  end

  assign sync.level = level_q;
  assign sync.rise = level_q & ~prev_q;
  assign sync.fall = ~level_q & prev_q;
endmodule : pin_sync
`default_nettype wire

// ### hw/input_output_ports.sv
// Memory-mapped four-bit input port with interrupt flag and two-bit output latch.
// Operation
// (RL1) A read of the input level register returns pins 3..0 on bits 3..0, high as 1, and writes do nothing.
// (RL2) The input level register holds no reset value and always shows the present pin levels; the code clears its synchroniser to 0 on reset.
// (RL3) Four read/write per-pin interrupt enable bits exist, 1 enables, and all clear on reset.
// (RL4) The input interrupt flag sits in bit 0 of its register, reads 1 after an input interrupt, and resets to 0.
// (RL5) Reading the flag register clears the flag right after the read.
// (RL6) Enabled input pins raise a processor interrupt request through the flag.
// (RL7) Unused bits read as 0: flag register bits 3..1 and output register bits 3..2.
// (RL8) Output pins 0 and 1 continuously drive output latch bits 0 and 1.
// (RL9) The output latch reads back its stored value so read-modify-write works.
// (RL10) Reset clears both output latch bits so both pins drive low.
// (RL11) With tone output chosen, latch bit 1 switches the tone on and off and resets to 0.
// (RL12) With divided-clock output chosen, latch bit 0 switches that output on and off and resets to 0.
// (RL13) Registers are one four-bit word per address in the I/O range and are reached only as whole words.
// (RL14) A build option picks plain or special output per pin: tone on pin 1, divided clock or inverted tone on pin 0.
// (RL15) The edge that sets the flag is a parameter, and the request stands while the flag and any enable are set.
`timescale 1ns/1ps
`default_nettype none
module input_output_ports #(
  parameter io_port_pkg::pin0_mode_t PIN0_MODE = io_port_pkg::PIN0_PLAIN,
  parameter io_port_pkg::pin1_mode_t PIN1_MODE = io_port_pkg::PIN1_PLAIN,
  parameter io_port_pkg::irq_edge_t IRQ_EDGE = io_port_pkg::EDGE_RISE
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Processor I/O word access
  input wire logic [io_port_pkg::ADDR_W-1:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [io_port_pkg::DATA_W-1:0] io_wdata,
  output logic [io_port_pkg::DATA_W-1:0] io_rdata,
  output logic input_irq_req,
  // Special output sources from the dividers
  input wire logic tone_clk,
  input wire logic div_clk,
  // Pins
  input wire logic [io_port_pkg::IN_W-1:0] input_pins,
  output logic output_pin0,
  output logic output_pin1
);
  // A mode code the output mux cannot serve is refused at elaboration.
  if (PIN0_MODE != io_port_pkg::PIN0_PLAIN && PIN0_MODE != io_port_pkg::PIN0_DIV_CLK &&
      PIN0_MODE != io_port_pkg::PIN0_TONE_N) begin : g_bad_pin0
    $error("Unsupported output pin 0 mode.");
  end
  if (IRQ_EDGE != io_port_pkg::EDGE_RISE && IRQ_EDGE != io_port_pkg::EDGE_FALL &&
      IRQ_EDGE != io_port_pkg::EDGE_BOTH) begin : g_bad_edge
    $error("Unsupported input interrupt edge.");
  end

  function automatic logic hit(input logic [io_port_pkg::ADDR_W-1:0] a,
                               input logic [io_port_pkg::ADDR_W-1:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  pin_sync_if #(.W(io_port_pkg::IN_W)) sync ();

  pin_sync #(.W(io_port_pkg::IN_W)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pins(input_pins),
    .sync(sync)
  );

  logic [io_port_pkg::IN_W-1:0] enable_q, enable_d;
  logic flag_q, flag_d;
  logic [io_port_pkg::OUT_W-1:0] latch_q, latch_d;
  logic [io_port_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic pin0_q, pin0_d;
  logic pin1_q, pin1_d;
  logic [io_port_pkg::IN_W-1:0] pin_event;
  logic flag_set;

  // The chosen edge of any enabled pin is an input interrupt event.
  always_comb begin
    unique case (IRQ_EDGE)
      io_port_pkg::EDGE_RISE: pin_event = sync.rise;
      io_port_pkg::EDGE_FALL: pin_event = sync.fall;
      io_port_pkg::EDGE_BOTH: pin_event = sync.rise | sync.fall;
      default: pin_event = sync.rise;
    endcase
  end
  assign flag_set = |(pin_event & enable_q); // RL6 RL15

  // Register writes and the read side effect.
  always_comb begin
    enable_d = enable_q;
    latch_d = latch_q;
    flag_d = flag_q;
    if (io_wr && hit(io_addr, io_port_pkg::INPUT_IRQ_ENABLE_ADDR)) begin
      enable_d = io_wdata; // RL3 RL13
    end
    if (io_wr && hit(io_addr, io_port_pkg::OUTPUT_LATCH_ADDR)) begin
      latch_d = io_wdata[io_port_pkg::OUT_W-1:0]; // RL8 RL11 RL12
    end
    // A new event in the same cycle as the clearing read is kept.
    if (io_rd && hit(io_addr, io_port_pkg::INPUT_IRQ_FLAG_ADDR)) begin
      flag_d = 1'b0; // RL5
    end
    if (flag_set) begin
      flag_d = 1'b1; // RL4 RL6
    end
  end

  // Read data are registered and appear the cycle after the strobe.
  always_comb begin
    rdata_d = io_port_pkg::RDATA_RESET;
    if (io_rd) begin
      if (hit(io_addr, io_port_pkg::INPUT_LEVEL_ADDR)) begin
        rdata_d = sync.level; // RL1 RL2
      end else if (hit(io_addr, io_port_pkg::INPUT_IRQ_ENABLE_ADDR)) begin
        rdata_d = enable_q; // RL3
      end else if (hit(io_addr, io_port_pkg::INPUT_IRQ_FLAG_ADDR)) begin
        rdata_d[io_port_pkg::FLAG_BIT] = flag_q; // RL4 RL7
      end else if (hit(io_addr, io_port_pkg::OUTPUT_LATCH_ADDR)) begin
        rdata_d[io_port_pkg::OUT_W-1:0] = latch_q; // RL9 RL7
      end
    end
  end

  // Output pin drivers; special sources are gated by their latch bit.
  always_comb begin
    pin1_d = latch_q[io_port_pkg::OUT1_BIT]; // RL8
    if (PIN1_MODE == io_port_pkg::PIN1_TONE) begin
      pin1_d = latch_q[io_port_pkg::OUT1_BIT] & tone_clk; // RL11 RL14
    end
    unique case (PIN0_MODE)
      io_port_pkg::PIN0_PLAIN: pin0_d = latch_q[io_port_pkg::OUT0_BIT]; // RL8
      io_port_pkg::PIN0_DIV_CLK: pin0_d = latch_q[io_port_pkg::OUT0_BIT] & div_clk; // RL12 RL14
      io_port_pkg::PIN0_TONE_N: pin0_d = latch_q[io_port_pkg::OUT1_BIT] & ~tone_clk; // RL11 RL14
      default: pin0_d = latch_q[io_port_pkg::OUT0_BIT];
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      enable_q <= io_port_pkg::ENABLE_RESET; // RL3
      flag_q <= io_port_pkg::FLAG_RESET; // RL4
      latch_q <= io_port_pkg::LATCH_RESET; // RL10
      rdata_q <= io_port_pkg::RDATA_RESET;
      pin0_q <= io_port_pkg::LATCH_RESET[io_port_pkg::OUT0_BIT]; // RL10
      pin1_q <= io_port_pkg::LATCH_RESET[io_port_pkg::OUT1_BIT]; // RL10
    end else begin
      enable_q <= enable_d;
      flag_q <= flag_d;
      latch_q <= latch_d;
      rdata_q <= rdata_d;
      pin0_q <= pin0_d;
      pin1_q <= pin1_d;
    end
  end

  assign io_rdata = rdata_q;
  assign output_pin0 = pin0_q;
  assign output_pin1 = pin1_q;
  assign input_irq_req = flag_q & (|enable_q); // RL15

  // Checks on the port behaviour.
  a_input_read_level: assert property (@(posedge clk_sys) disable iff (reset) // RL1
    io_rd && io_addr == io_port_pkg::INPUT_LEVEL_ADDR |=> io_rdata == $past(sync.level))
    else $error("Input level read returned wrong data.");

  a_input_write_ignored: assert property (@(posedge clk_sys) disable iff (reset) // RL1
    io_wr && io_addr == io_port_pkg::INPUT_LEVEL_ADDR |=> $stable(enable_q) && $stable(latch_q))
    else $error("Write to input level register changed state.");

  a_enable_write_read: assert property (@(posedge clk_sys) disable iff (reset) // RL3
    io_wr && io_addr == io_port_pkg::INPUT_IRQ_ENABLE_ADDR && !io_rd ##1 io_rd &&
    io_addr == io_port_pkg::INPUT_IRQ_ENABLE_ADDR && !io_wr |=> io_rdata == $past(io_wdata, 2))
    else $error("Enable register did not read back written value.");

  a_flag_read_clear: assert property (@(posedge clk_sys) disable iff (reset) // RL5
    io_rd && io_addr == io_port_pkg::INPUT_IRQ_FLAG_ADDR && !flag_set |=> !flag_q)
    else $error("Flag not cleared after read.");

  a_flag_set_event: assert property (@(posedge clk_sys) disable iff (reset) // RL6
    |(sync.rise & enable_q) && IRQ_EDGE == io_port_pkg::EDGE_RISE &&
    !(io_wr && io_addr == io_port_pkg::INPUT_IRQ_ENABLE_ADDR) |=> flag_q && input_irq_req)
    else $error("Enabled input edge did not set the flag.");

  a_flag_read_bits: assert property (@(posedge clk_sys) disable iff (reset) // RL7
    io_rd && io_addr == io_port_pkg::INPUT_IRQ_FLAG_ADDR |=> io_rdata == {3'h0, $past(flag_q)})
    else $error("Flag register read wrong.");

  a_latch_readback: assert property (@(posedge clk_sys) disable iff (reset) // RL9
    io_wr && io_addr == io_port_pkg::OUTPUT_LATCH_ADDR && !io_rd ##1 io_rd &&
    io_addr == io_port_pkg::OUTPUT_LATCH_ADDR && !io_wr |=> io_rdata == {2'h0, $past(io_wdata[1:0], 2)})
    else $error("Output latch read back wrong.");

  a_pin_follows_latch: assert property (@(posedge clk_sys) disable iff (reset) // RL8
    PIN0_MODE == io_port_pkg::PIN0_PLAIN && io_wr && io_addr == io_port_pkg::OUTPUT_LATCH_ADDR
    |=> ##1 output_pin0 == $past(io_wdata[0], 2))
    else $error("Output pin 0 does not follow the latch.");

  a_irq_needs_enable: assert property (@(posedge clk_sys) disable iff (reset) // RL15
    enable_q == io_port_pkg::ENABLE_RESET && !flag_q |=> !input_irq_req)
    else $error("Masked input raised the interrupt request.");

  // Any address outside the four registers must read as zero.
  a_unmapped_read_zero: assert property (@(posedge clk_sys) disable iff (reset) // RL13
    io_rd && io_addr != io_port_pkg::INPUT_LEVEL_ADDR && io_addr != io_port_pkg::INPUT_IRQ_ENABLE_ADDR &&
    io_addr != io_port_pkg::INPUT_IRQ_FLAG_ADDR && io_addr != io_port_pkg::OUTPUT_LATCH_ADDR
    |=> io_rdata == io_port_pkg::RDATA_RESET)
    else $error("Unmapped read returned nonzero data.");

  a_pin1_follows_latch: assert property (@(posedge clk_sys) disable iff (reset) // RL8
    PIN1_MODE == io_port_pkg::PIN1_PLAIN && io_wr && io_addr == io_port_pkg::OUTPUT_LATCH_ADDR
    |=> ##1 output_pin1 == $past(io_wdata[io_port_pkg::OUT1_BIT], 2))
    else $error("Output pin 1 does not follow the latch.");

  a_flag_holds: assert property (@(posedge clk_sys) disable iff (reset) // RL4
    flag_q && !(io_rd && io_addr == io_port_pkg::INPUT_IRQ_FLAG_ADDR) |=> flag_q)
    else $error("Flag dropped without a read.");

  c_flag_read: cover property (@(posedge clk_sys) disable iff (reset)
    flag_q && io_rd && io_addr == io_port_pkg::INPUT_IRQ_FLAG_ADDR);
  c_set_during_clear: cover property (@(posedge clk_sys) disable iff (reset)
    flag_set && io_rd && io_addr == io_port_pkg::INPUT_IRQ_FLAG_ADDR);
  c_latch_both_high: cover property (@(posedge clk_sys) disable iff (reset) latch_q == 2'h3);
  c_irq_raised: cover property (@(posedge clk_sys) disable iff (reset) $rose(input_irq_req));
  c_special_on: cover property (@(posedge clk_sys) disable iff (reset)
    latch_q != io_port_pkg::LATCH_RESET && (tone_clk || div_clk));
endmodule : input_output_ports
`default_nettype wire

// ### verif/pin_env.sv
// External switches on the input pins and loads on the two output pins.
`timescale 1ns/1ps
`default_nettype none
module pin_env (
  // Clock
  input wire logic clk_sys,
  // Pins
  output logic [3:0] input_pins,
  input wire logic output_pin0,
  input wire logic output_pin1,
  // Level seen by the loads
  output logic [1:0] load_level
);
  // The switches sit on pull-downs, so an open switch reads low from time zero.
  initial input_pins = 4'h0;
  assign load_level = {output_pin1, output_pin0};
  // Switches move just after a clock edge, like a settled mechanical contact.
  task automatic set_pins(input logic [3:0] v);
    @(posedge clk_sys);
    input_pins <= v;
  endtask : set_pins
endmodule : pin_env
`default_nettype wire

// ### verif/tb_input_output_ports.sv
// Self-checking bench for the input and output port block.
`timescale 1ns/1ps
`default_nettype none
module tb_input_output_ports;
  logic clk_sys, reset, io_rd, io_wr, tone_clk, div_clk, input_irq_req, output_pin0, output_pin1;
  logic [7:0] io_addr;
  logic [3:0] io_wdata, io_rdata, input_pins, rd;
  logic [1:0] load_level;
  logic sp_pin0, sp_pin1, tn_pin0, tn_pin1, sp_irq, tn_irq;
  int errors, tests_run;
  input_output_ports dut_u (.clk_sys(clk_sys), .reset(reset), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .input_irq_req(input_irq_req), .tone_clk(tone_clk),
    .div_clk(div_clk), .input_pins(input_pins), .output_pin0(output_pin0), .output_pin1(output_pin1));
  pin_env env_u (.clk_sys(clk_sys), .input_pins(input_pins), .output_pin0(output_pin0),
    .output_pin1(output_pin1), .load_level(load_level));
  // Two more builds share the bus and pins so that every output mode and edge choice is exercised.
  input_output_ports #(.PIN0_MODE(io_port_pkg::PIN0_DIV_CLK), .PIN1_MODE(io_port_pkg::PIN1_TONE),
    .IRQ_EDGE(io_port_pkg::EDGE_FALL)) dut_sp_u (.clk_sys(clk_sys), .reset(reset), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(), .input_irq_req(sp_irq),
    .tone_clk(tone_clk), .div_clk(div_clk), .input_pins(input_pins), .output_pin0(sp_pin0),
    .output_pin1(sp_pin1));
  input_output_ports #(.PIN0_MODE(io_port_pkg::PIN0_TONE_N), .PIN1_MODE(io_port_pkg::PIN1_PLAIN),
    .IRQ_EDGE(io_port_pkg::EDGE_BOTH)) dut_tn_u (.clk_sys(clk_sys), .reset(reset), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(), .input_irq_req(tn_irq),
    .tone_clk(tone_clk), .div_clk(div_clk), .input_pins(input_pins), .output_pin0(tn_pin0),
    .output_pin1(tn_pin1));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // One whole-word access; read data is taken at the edge after the strobe.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] d);
    @(posedge clk_sys);
    io_rd <= ~wr;
    io_wr <= wr;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    #1 rd = io_rdata;
  endtask : acc
  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask : settle
  task automatic t_reset();
    acc(1'b0, 8'he8, 4'h0); chk(rd, 4'h0);
    acc(1'b0, 8'hed, 4'h0); chk(rd, 4'h0);
    acc(1'b0, 8'hf3, 4'h0); chk(rd, 4'h0);
    chk({2'h0, load_level}, 4'h0);
    chk({tn_pin1, tn_pin0, sp_pin1, sp_pin0}, 4'h0);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_level();
    env_u.set_pins(4'ha);
    settle();
    acc(1'b0, 8'he0, 4'h0); chk(rd, 4'ha);
    acc(1'b1, 8'he0, 4'h5);
    acc(1'b0, 8'he0, 4'h0); chk(rd, 4'ha);
    env_u.set_pins(4'h5);
    settle();
    acc(1'b0, 8'he0, 4'h0); chk(rd, 4'h5);
    $display("test input level done");
  endtask : t_level
  task automatic t_enable();
    acc(1'b1, 8'he8, 4'hf);
    acc(1'b0, 8'he8, 4'h0); chk(rd, 4'hf);
    acc(1'b1, 8'he8, 4'h0);
    acc(1'b0, 8'he8, 4'h0); chk(rd, 4'h0);
    $display("test enables done");
  endtask : t_enable
  task automatic t_irq();
    int n;
    env_u.set_pins(4'h0);
    settle();
    acc(1'b0, 8'hed, 4'h0);
    acc(1'b1, 8'he8, 4'h1);
    env_u.set_pins(4'h2);
    settle();
    chk({3'h0, input_irq_req}, 4'h0);
    acc(1'b0, 8'hed, 4'h0); chk(rd, 4'h0);
    env_u.set_pins(4'h3);
    n = 0;
    while (input_irq_req !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (input_irq_req !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: interrupt request never rose", $time);
      wrap_up();
    end
    chk({3'h0, input_irq_req}, 4'h1);
    chk({2'h0, tn_irq, sp_irq}, 4'h2);
    acc(1'b0, 8'hed, 4'h0); chk(rd, 4'h1);
    chk({3'h0, input_irq_req}, 4'h0);
    acc(1'b0, 8'hed, 4'h0); chk(rd, 4'h0);
    // A falling edge on the enabled pin flags only the builds that watch falling edges.
    env_u.set_pins(4'h2);
    settle();
    chk({1'b0, input_irq_req, tn_irq, sp_irq}, 4'h3);
    acc(1'b0, 8'hed, 4'h0); chk(rd, 4'h0);
    chk({1'b0, input_irq_req, tn_irq, sp_irq}, 4'h0);
    $display("test input interrupt done");
  endtask : t_irq
  task automatic t_out();
    acc(1'b1, 8'hf3, 4'hf);
    acc(1'b0, 8'hf3, 4'h0); chk(rd, 4'h3);
    chk({2'h0, load_level}, 4'h3);
    acc(1'b1, 8'hf3, rd & 4'he);
    acc(1'b0, 8'hf3, 4'h0); chk(rd, 4'h2);
    chk({2'h0, load_level}, 4'h2);
    acc(1'b0, 8'he1, 4'h0); chk(rd, 4'h0);
    acc(1'b1, 8'he1, 4'h3);
    acc(1'b0, 8'hf3, 4'h0); chk(rd, 4'h2);
    $display("test output latch done");
  endtask : t_out
  // The special sources pass through only while their latch bit is set, one cycle late.
  task automatic t_special();
    acc(1'b1, 8'hf3, 4'h3);
    @(posedge clk_sys);
    tone_clk <= 1'b1;
    @(posedge clk_sys);
    #1 chk({tn_pin1, tn_pin0, sp_pin1, sp_pin0}, 4'ha);
    chk({2'h0, load_level}, 4'h3);
    @(posedge clk_sys);
    tone_clk <= 1'b0;
    div_clk <= 1'b1;
    @(posedge clk_sys);
    #1 chk({tn_pin1, tn_pin0, sp_pin1, sp_pin0}, 4'hd);
    acc(1'b1, 8'hf3, 4'h0);
    @(posedge clk_sys);
    #1 chk({tn_pin1, tn_pin0, sp_pin1, sp_pin0}, 4'h0);
    $display("test special outputs done");
  endtask : t_special
  // Write and read back in consecutive cycles, which the bus allows.
  task automatic t_b2b();
    @(posedge clk_sys);
    io_wr <= 1'b1;
    io_addr <= 8'he8;
    io_wdata <= 4'h9;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    #1 chk(io_rdata, 4'h9);
    @(posedge clk_sys);
    io_wr <= 1'b1;
    io_addr <= 8'hf3;
    io_wdata <= 4'hd;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    #1 chk(io_rdata, 4'h1);
    chk({2'h0, load_level}, 4'h1);
    $display("test back-to-back access done");
  endtask : t_b2b
  // A second reset with state set must clear it again while the level register tracks the pins.
  task automatic t_midreset();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    acc(1'b0, 8'he0, 4'h0); chk(rd, 4'h2);
    $display("test reset in mid-run done");
  endtask : t_midreset
  initial begin
    errors = 0;
    tests_run = 0;
    reset = 1'b1;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_addr = 8'h00;
    io_wdata = 4'h0;
    tone_clk = 1'b0;
    div_clk = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_level();
    t_enable();
    t_irq();
    t_out();
    t_special();
    t_b2b();
    t_midreset();
    wrap_up();
  end
endmodule : tb_input_output_ports
`default_nettype wire
